//--- common/clk_sel_if.sv
/*
  Carrier between the register logic and the clock switch engine.
  Assumes both ends run on the same bus clock.
*/
`timescale 1ns/100ps
interface clk_sel_if;
  logic [2:0] init_src;
  logic [2:0] req_src;
  logic       permitted;
  logic [7:0] src_ready;
  logic       pll_ok;
  logic [2:0] cur_src;
  logic       busy;
  logic [2:0] clk_sel;
  logic       clk_gate;

  modport ctrl (output init_src, req_src, permitted, src_ready, pll_ok,
                input  cur_src, busy, clk_sel, clk_gate);
  modport eng  (input  init_src, req_src, permitted, src_ready, pll_ok,
                output cur_src, busy, clk_sel, clk_gate);
endinterface : clk_sel_if

//--- common/osc_pkg.sv
/*
  Types shared by the oscillator select control modules.
  Assumes nothing of its surroundings.
*/
package osc_pkg;

  typedef enum logic [2:0] {
    src_fast_rc        = 3'h0,
    src_fast_rc_pll    = 3'h1,
    src_primary        = 3'h2,
    src_primary_pll    = 3'h3,
    src_secondary      = 3'h4,
    src_low_power_rc   = 3'h5,
    src_fast_rc_div16  = 3'h6,
    src_fast_rc_divn   = 3'h7
  } source_e;

  typedef enum logic [1:0] {
    ul_locked = 2'h0,
    ul_half   = 2'h1,
    ul_open   = 2'h3
  } unlock_state_e;

  typedef enum logic [1:0] {
    sw_idle     = 2'h0,
    sw_gate_off = 2'h1,
    sw_wait     = 2'h3,
    sw_gate_on  = 2'h2
  } switch_state_e;

  // Sources that run through the system PLL
  function automatic logic is_pll_src(input logic [2:0] s);
    is_pll_src = (s == src_fast_rc_pll) || (s == src_primary_pll);
  endfunction : is_pll_src

endpackage : osc_pkg

//--- common/osc_regs.svh
/*
  Register offsets, field positions, reset values, unlock keys and timing
  counts of the oscillator select control block.
  Assumes a 125 MHz bus clock and 32-bit AXI4-Lite data.
*/
`ifndef OSC_REGS_SVH
`define OSC_REGS_SVH

////////////////////////////////////////////////////////////////////////////
// Address map
`define OSC_ADDR_W        8
`define OSC_CTRL_OFS      8'h00
`define OSC_KEY_OFS       8'h04

////////////////////////////////////////////////////////////////////////////
// Control register fields
`define OSC_DIV_MSB       26
`define OSC_DIV_LSB       24
`define OSC_FACT_MSB      18
`define OSC_FACT_LSB      16
`define OSC_CUR_MSB       14
`define OSC_CUR_LSB       12
`define OSC_REQ_MSB       10
`define OSC_REQ_LSB       8
`define OSC_LOCK_BIT      7
`define OSC_USB_PLL_LOCKED_BIT     6
`define OSC_SYSTEM_PLL_LOCKED_BIT     5
`define OSC_SLEEP_ON_WAIT_ENABLE_BIT     4

// Reset values of software fields
`define OSC_DIV_RST       3'h0
`define OSC_FACT_RST      3'h0
`define OSC_LOCK_RST      1'h0
`define OSC_SLEEP_ON_WAIT_ENABLE_RST     1'h0

////////////////////////////////////////////////////////////////////////////
// Unlock keys, values are arbitrary
`define OSC_KEY1          32'h0000C3A5
`define OSC_KEY2          32'h00005A3C

////////////////////////////////////////////////////////////////////////////
// AXI responses
`define OSC_RESP_OKAY     2'h0
`define OSC_RESP_SLVERR   2'h2
`define OSC_RESP_DECERR   2'h3

////////////////////////////////////////////////////////////////////////////
// Timing
`define OSC_CLK_NS        8
`define OSC_PLL_START_NS  100000
`define OSC_PLL_START_CYC \
  ((`OSC_PLL_START_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS)

`endif

//--- dv/osc_sel_properties.sv
/* Port checker for the oscillator select control block.
   Assumes it is bound to the top module; reset is synchronous, active low. */
`timescale 1ns/100ps
module osc_sel_properties (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // Clock selection
  input wire logic [4:0]  pll_factor,
  input wire logic        fast_rc_div_active,
  input wire logic [2:0]  clk_sel,
  input wire logic        clk_gate,
  input wire logic        switch_busy,
  // Power modes
  input wire logic        wait_instr,
  input wire logic        sleep_enter,
  input wire logic        idle_enter
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sw_start;
    $rose(switch_busy);
  endsequence
  sequence s_sw_done;
    $fell(switch_busy) && clk_gate;
  endsequence

  a_sw_gate_off: assert property (s_sw_start |-> !clk_gate)
    else $error("clock gate open at switch start");
  a_sw_finishes: assert property (s_sw_start |-> ##[1:300] s_sw_done)
    else $error("switch did not finish with gate on");
  a_busy_gated: assert property (switch_busy |-> !clk_gate)
    else $error("clock gate open while switching");
  a_sel_glitch: assert property ($changed(clk_sel) |-> !clk_gate)
    else $error("source select moved with gate open");
  a_fact_code: assert property (pll_factor inside {5'h0F, 5'h10, 5'h11,
    5'h12, 5'h13, 5'h14, 5'h15, 5'h18})
    else $error("multiplier outside the decode table");
  a_wait_pulse: assert property (wait_instr
    |=> sleep_enter != idle_enter)
    else $error("wait gave no single mode pulse");
  a_mode_cause: assert property ((sleep_enter || idle_enter)
    |-> $past(wait_instr))
    else $error("mode pulse without wait");
  a_div_select: assert property ($rose(fast_rc_div_active)
    |-> $past(clk_sel) == 3'h7)
    else $error("divider path active without code 7");
  a_b_answer: assert property (awvalid && awready && wvalid && wready
    |-> ##2 bvalid)
    else $error("write response late");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
endmodule : osc_sel_properties

//--- dv/osc_source_model.sv
/* Stand-in for the clock sources and the two PLLs.
   Assumes the bench gives the ready mask; locks follow enables. */
`timescale 1ns/100ps
module osc_source_model #(
  parameter int DLY = 6
) (
  // Clock
  input  wire logic       aclk,
  // Enables and readiness
  input  wire logic       sys_pll_enable,
  input  wire logic       usb_pll_enable,
  input  wire logic [7:0] ready_mask,
  // Status pins
  output logic [7:0]      src_ready_pin,
  output logic            sys_pll_lock_pin,
  output logic            usb_pll_lock_pin
);
  int sys_n = 0;
  int usb_n = 0;
  always @(posedge aclk) begin
    sys_n <= sys_pll_enable ? sys_n + 1 : 0;
    usb_n <= usb_pll_enable ? usb_n + 1 : 0;
  end
  // Lock only after a start-up delay, lost at once on disable
  assign sys_pll_lock_pin = sys_n > DLY;
  assign usb_pll_lock_pin = usb_n > DLY;
  assign src_ready_pin    = ready_mask;
endmodule : osc_source_model

//--- dv/test_oscillator_select_control.sv
/* Self-checking bench for the oscillator select control block.
   Assumes the package, header, design and source model are compiled. */
`timescale 1ns/100ps
`include "osc_regs.svh"
module test_oscillator_select_control;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, usb_pll_enable = 0, wait_instr = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [2:0]  awprot = 0, arprot = 0, initial_source_config = 3'h2;
  logic [31:0] wdata = 0, lfsr = 32'h2540D215;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  switch_monitor_config = 0;
  logic        awready, wready, bvalid, arready, rvalid, sys_pll_enable;
  logic        fast_rc_div_active, clk_gate, switch_busy, sleep_enter;
  logic        idle_enter, sys_pll_lock_pin, usb_pll_lock_pin;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  src_ready_pin;
  logic [4:0]  pll_factor;
  logic [2:0]  fast_rc_div_code, clk_sel;
  int          failures = 0, n_tests = 0;

  oscillator_select_control #(.PLL_START_CYC(8)) u_dut (.*);
  osc_source_model u_src (.aclk, .sys_pll_enable, .usb_pll_enable,
    .ready_mask(8'hFF), .src_ready_pin, .sys_pll_lock_pin, .usb_pll_lock_pin);

  always #4 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] cw(input logic [2:0] dv, f, rq,
                                     input logic lk, sl);
    return {5'h0, dv, 5'h0, f, 5'h0, rq, lk, 2'h0, sl, 4'h0};
  endfunction : cw
  function automatic logic [31:0] ex(input logic [2:0] cur, input logic u, s);
    return {17'h0, cur, 12'h0} | {25'h0, u, s, 5'h0};
  endfunction : ex
  function automatic logic [4:0] fx(input logic [2:0] c);
    return (c == 3'h7) ? 5'h18 : 5'h0F + c;
  endfunction : fx
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : step

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic conclude;
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic boot(input logic [1:0] c, input logic [2:0] s);
    aresetn <= 1'b0;
    switch_monitor_config <= c;
    initial_source_config <= s;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : boot
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk("bresp", er, bresp);
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    @(posedge aclk);
  endtask : rd
  task automatic rctl(input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(`OSC_CTRL_OFS, d, r);
    chk("control", e, d);
    chk("rresp", `OSC_RESP_OKAY, r);
  endtask : rctl
  task automatic uwr(input logic [31:0] d);
    wr(`OSC_KEY_OFS, `OSC_KEY1, `OSC_RESP_OKAY);
    wr(`OSC_KEY_OFS, `OSC_KEY2, `OSC_RESP_OKAY);
    wr(`OSC_CTRL_OFS, d, `OSC_RESP_OKAY);
  endtask : uwr
  task automatic sw_wait;
    repeat (3) @(posedge aclk);
    while (switch_busy) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask : sw_wait

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [2:0]  t;
    boot(2'h0, 3'h2);
    rctl(ex(3'h2, 0, 0) | cw(0, 0, 3'h2, 0, 0));
    chk("factor", 5'h0F, pll_factor);
    wr(`OSC_CTRL_OFS, cw(0, 3'h1, 0, 0, 0), `OSC_RESP_SLVERR);
    rctl(ex(3'h2, 0, 0) | cw(0, 0, 3'h2, 0, 0));
    for (int i = 0; i < 8; i++) begin
      lfsr = step(lfsr);
      uwr(cw(lfsr[2:0], i[2:0], 3'h2, 0, lfsr[4]));
      wait_instr <= 1'b1;
      @(posedge aclk);
      wait_instr <= 1'b0;
      @(posedge aclk);
      chk("sleep", lfsr[4], sleep_enter);
      chk("idle", !lfsr[4], idle_enter);
      chk("factor", fx(i[2:0]), pll_factor);
      chk("divider", lfsr[2:0], fast_rc_div_code);
    end
    for (int i = 0; i < 8; i++) begin
      t = 3'(7 - i);
      uwr(cw(0, 0, t, 0, 0));
      sw_wait();
      rctl(ex(t, 0, t == 3'h1 || t == 3'h3) | cw(0, 0, t, 0, 0));
      chk("select", t, clk_sel);
      chk("pll_enable", t == 3'h1 || t == 3'h3, sys_pll_enable);
      chk("div_active", t == 3'h7, fast_rc_div_active);
    end
    usb_pll_enable <= 1'b1;
    repeat (20) @(posedge aclk);
    rctl(ex(0, 1, 0));
    usb_pll_enable <= 1'b0;
    repeat (4) @(posedge aclk);
    rctl(ex(0, 0, 0));
    rd(8'h10, d, r);
    chk("unmapped", 0, d);
    chk("rresp", `OSC_RESP_DECERR, r);
    wr(8'h10, 32'h1, `OSC_RESP_DECERR);
    uwr(cw(0, 0, 0, 1, 0));
    uwr(cw(0, 3'h3, 3'h5, 1, 0));
    sw_wait();
    rctl(ex(3'h5, 0, 0) | cw(0, 3'h3, 3'h5, 1, 0));
    chk("factor", 5'h12, pll_factor);
    boot(2'h2, 3'h4);
    rctl(ex(3'h4, 0, 0) | cw(0, 0, 3'h4, 0, 0));
    uwr(cw(0, 0, 3'h4, 1, 0));
    uwr(cw(3'h3, 3'h5, 0, 1, 1));
    sw_wait();
    rctl(ex(3'h4, 0, 0) | cw(0, 0, 3'h4, 1, 1));
    chk("factor", 5'h0F, pll_factor);
    uwr(cw(0, 0, 3'h4, 0, 0));
    uwr(cw(0, 0, 3'h6, 0, 0));
    sw_wait();
    rctl(ex(3'h6, 0, 0) | cw(0, 0, 3'h6, 0, 0));
    conclude();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    conclude();
  end
endmodule : test_oscillator_select_control

bind oscillator_select_control osc_sel_properties u_props (.*);

//--- rtl/clk_switch.sv
/*
  Glitch-free clock switch sequencer: gate off, wait ready, reselect, gate on.
  Assumes source ready and PLL status already synchronised to aclk.
*/
`timescale 1ns/100ps
module clk_switch (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Register side
  clk_sel_if.eng    sel
);

  osc_pkg::switch_state_e state_r, state_nxt;
  logic [2:0] target_r, target_nxt;
  logic [2:0] cur_nxt, sel_nxt;
  logic       gate_nxt;

  always_comb begin
    state_nxt  = state_r;
    target_nxt = target_r;
    cur_nxt    = sel.cur_src;
    sel_nxt    = sel.clk_sel;
    gate_nxt   = sel.clk_gate;
    case (state_r)
      osc_pkg::sw_idle: begin
        if (sel.permitted && sel.req_src != sel.cur_src) begin
          target_nxt = sel.req_src;
          gate_nxt   = 1'b0;
          state_nxt  = osc_pkg::sw_gate_off;
        end
      end
      osc_pkg::sw_gate_off: begin
        state_nxt = osc_pkg::sw_wait;
      end
      osc_pkg::sw_wait: begin
        // Old clock is gated, so the select may move safely
        if (sel.src_ready[target_r] &&
            (!osc_pkg::is_pll_src(target_r) || sel.pll_ok)) begin
          sel_nxt   = target_r;
          state_nxt = osc_pkg::sw_gate_on;
        end
      end
      osc_pkg::sw_gate_on: begin
        gate_nxt  = 1'b1;
        cur_nxt   = target_r;
        state_nxt = osc_pkg::sw_idle;
      end
      default: state_nxt = osc_pkg::sw_idle;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r      <= osc_pkg::sw_idle;
      target_r     <= sel.init_src;
      sel.cur_src  <= sel.init_src;
      sel.clk_sel  <= sel.init_src;
      sel.clk_gate <= 1'b1;
      sel.busy     <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      target_r     <= target_nxt;
      sel.cur_src  <= cur_nxt;
      sel.clk_sel  <= sel_nxt;
      sel.clk_gate <= gate_nxt;
      sel.busy     <= (state_nxt != osc_pkg::sw_idle);
    end
  end

endmodule : clk_switch

//--- rtl/osc_unlock.sv
/*
  Write unlock sequencer: two key writes open one control write.
  Assumes one-cycle write strobes from the bus slave on the same clock.
*/
`timescale 1ns/100ps
`include "osc_regs.svh"
module osc_unlock (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write events
  input  wire logic        key_wr,
  input  wire logic [31:0] key_data,
  input  wire logic        ctrl_wr,
  // Status
  output logic             unlocked
);

  osc_pkg::unlock_state_e state_r, state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      osc_pkg::ul_locked: begin
        if (key_wr && key_data == `OSC_KEY1)
          state_nxt = osc_pkg::ul_half;
      end
      osc_pkg::ul_half: begin
        if (key_wr && key_data == `OSC_KEY2)
          state_nxt = osc_pkg::ul_open;
        else if (key_wr || ctrl_wr)
          state_nxt = osc_pkg::ul_locked;
      end
      osc_pkg::ul_open: begin
        // One write consumes the unlock
        if (ctrl_wr)
          state_nxt = osc_pkg::ul_locked;
        else if (key_wr)
          state_nxt = (key_data == `OSC_KEY1) ? osc_pkg::ul_half
                                              : osc_pkg::ul_locked;
      end
      default: state_nxt = osc_pkg::ul_locked;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r  <= osc_pkg::ul_locked;
      unlocked <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      unlocked <= (state_nxt == osc_pkg::ul_open);
    end
  end

endmodule : osc_unlock

//--- rtl/oscillator_select_control.sv
/*
  Oscillator select control: AXI4-Lite register slave, write unlock,
  PLL lock status, wait-mode choice and glitch-free source switching.
  Assumes configuration inputs are static and on aclk; lock and ready
  pins are asynchronous and are synchronised here.
*/
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
// Contract
// - PLL factor code at bits 18:16 means 15,16,17,18,19,20,21,24.
// - Bits 14:12 read the active clock source, read only.
// - Bits 10:8 hold the requested source, same encodings.
// - Reset loads the requested source from the initial source config.
// - Config 1x: lock bit set freezes source and PLL selections.
// - Config 0x: selections never freeze, whatever the lock bit.
// - Bit 6 set when USB PLL locked or its start timer expired.
// - Bit 5 set when system PLL locked or its start timer expired.
// - Wait instruction enters Sleep if bit 4 set, else Idle.
// - Control writes are accepted only after the unlock key sequence.
// - Bits 15 and 11 read as zero.
// - Source 111 divides fast RC by divider field bits 26:24.
`timescale 1ns/100ps
`include "osc_regs.svh"
module oscillator_select_control #(
  parameter int ADDR_W        = `OSC_ADDR_W,
  parameter int PLL_START_CYC = `OSC_PLL_START_CYC
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Configuration
  input  wire logic [2:0]        initial_source_config,
  input  wire logic [1:0]        switch_monitor_config,
  // Clock sources and PLLs
  input  wire logic [7:0]        src_ready_pin,
  input  wire logic              sys_pll_lock_pin,
  input  wire logic              usb_pll_lock_pin,
  input  wire logic              usb_pll_enable,
  output logic                   sys_pll_enable,
  output logic [4:0]             pll_factor,
  output logic [2:0]             fast_rc_div_code,
  output logic                   fast_rc_div_active,
  output logic [2:0]             clk_sel,
  output logic                   clk_gate,
  output logic                   switch_busy,
  // Power modes
  input  wire logic              wait_instr,
  output logic                   sleep_enter,
  output logic                   idle_enter
);

  localparam int TW = $clog2(PLL_START_CYC + 1);
  localparam logic [TW-1:0] START_MAX = TW'(PLL_START_CYC);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [9:0] pin_s1_r, pin_s2_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 10'h000;
      pin_s2_r <= 10'h000;
    end else begin
      pin_s1_r <= {sys_pll_lock_pin, usb_pll_lock_pin, src_ready_pin};
      pin_s2_r <= pin_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PLL start-up timers: index 0 system, index 1 USB
  logic [1:0] tmr_en, tmr_done;
  assign tmr_en = {usb_pll_enable, sys_pll_enable};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      logic [TW-1:0] cnt_r, cnt_nxt;
      always_comb begin
        cnt_nxt = cnt_r;
        if (!tmr_en[g])
          cnt_nxt = '0;
        else if (cnt_r != START_MAX)
          cnt_nxt = TW'(cnt_r + 1'b1);
      end
      always_ff @(posedge aclk) begin
        if (!aresetn)
          cnt_r <= '0;
        else
          cnt_r <= cnt_nxt;
      end
      assign tmr_done[g] = tmr_en[g] && (cnt_r == START_MAX);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Submodules
  clk_sel_if sel_if ();
  logic unlocked;
  logic key_wr, ctrl_wr;
  logic [31:0] wdata_r, wdata_nxt;

  osc_unlock u_unlock (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .key_wr   (key_wr),
    .key_data (wdata_r),
    .ctrl_wr  (ctrl_wr),
    .unlocked (unlocked)
  );

  clk_switch u_switch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sel     (sel_if.eng)
  );

  ////////////////////////////////////////////////////////////////////////
  // State
  logic [2:0]        div_r, div_nxt, fact_r, fact_nxt, req_r, req_nxt;
  logic              lock_r, lock_nxt, sleep_on_wait_enable_r, sleep_on_wait_enable_nxt;
  logic              usb_pll_locked_r, usb_pll_locked_nxt, system_pll_locked_r, system_pll_locked_nxt;
  logic              pll_en_nxt, sleep_nxt, idle_nxt;
  logic [4:0]        factor_nxt;
  logic              aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0]       rdata_nxt, ctrl_word;
  logic [3:0]        wstrb_r, wstrb_nxt;
  logic              awready_nxt, wready_nxt, bvalid_nxt;
  logic              arready_nxt, rvalid_nxt;
  logic [1:0]        bresp_nxt, rresp_nxt;
  logic              frozen, write_go;

  assign frozen   = switch_monitor_config[1] && lock_r;
  assign write_go = aw_held_r && w_held_r && !bvalid;
  assign key_wr   = write_go && (aw_addr_r == ADDR_W'(`OSC_KEY_OFS));
  assign ctrl_wr  = write_go && (aw_addr_r == ADDR_W'(`OSC_CTRL_OFS));

  assign sel_if.init_src  = initial_source_config;
  assign sel_if.req_src   = req_r;
  assign sel_if.permitted = !frozen;
  assign sel_if.src_ready = pin_s2_r[7:0];
  assign sel_if.pll_ok    = system_pll_locked_r;
  assign clk_sel          = sel_if.clk_sel;
  assign clk_gate         = sel_if.clk_gate;
  assign switch_busy      = sel_if.busy;

  // PLL multiplier decode
  function automatic logic [4:0] fact_decode(input logic [2:0] c);
    case (c)
      3'h0:    fact_decode = 5'h0F;
      3'h1:    fact_decode = 5'h10;
      3'h2:    fact_decode = 5'h11;
      3'h3:    fact_decode = 5'h12;
      3'h4:    fact_decode = 5'h13;
      3'h5:    fact_decode = 5'h14;
      3'h6:    fact_decode = 5'h15;
      default: fact_decode = 5'h18;
    endcase
  endfunction : fact_decode

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`OSC_DIV_MSB:`OSC_DIV_LSB]   = div_r;
    ctrl_word[`OSC_FACT_MSB:`OSC_FACT_LSB] = fact_r;
    ctrl_word[`OSC_CUR_MSB:`OSC_CUR_LSB]   = sel_if.cur_src;
    ctrl_word[`OSC_REQ_MSB:`OSC_REQ_LSB]   = req_r;
    ctrl_word[`OSC_LOCK_BIT]               = lock_r;
    ctrl_word[`OSC_USB_PLL_LOCKED_BIT]              = usb_pll_locked_r;
    ctrl_word[`OSC_SYSTEM_PLL_LOCKED_BIT]              = system_pll_locked_r;
    ctrl_word[`OSC_SLEEP_ON_WAIT_ENABLE_BIT]              = sleep_on_wait_enable_r;

    div_nxt     = div_r;
    fact_nxt    = fact_r;
    req_nxt     = req_r;
    lock_nxt    = lock_r;
    sleep_on_wait_enable_nxt   = sleep_on_wait_enable_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    aw_addr_nxt = aw_addr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    awready_nxt = awready;
    wready_nxt  = wready;
    bvalid_nxt  = bvalid;
    bresp_nxt   = bresp;
    arready_nxt = arready;
    rvalid_nxt  = rvalid;
    rdata_nxt   = rdata;
    rresp_nxt   = rresp;

    // Address and data are taken independently
    if (awvalid && awready) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = awaddr;
      awready_nxt = 1'b0;
    end
    if (wvalid && wready) begin
      w_held_nxt  = 1'b1;
      wdata_nxt   = wdata;
      wstrb_nxt   = wstrb;
      wready_nxt  = 1'b0;
    end

    if (write_go) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = `OSC_RESP_OKAY;
      if (ctrl_wr) begin
        if (!unlocked) begin
          bresp_nxt = `OSC_RESP_SLVERR;
        end else begin
          if (wstrb_r[3] && !frozen)
            div_nxt = wdata_r[`OSC_DIV_MSB:`OSC_DIV_LSB];
          if (wstrb_r[2] && !frozen)
            fact_nxt = wdata_r[`OSC_FACT_MSB:`OSC_FACT_LSB];
          if (wstrb_r[1] && !frozen)
            req_nxt = wdata_r[`OSC_REQ_MSB:`OSC_REQ_LSB];
          if (wstrb_r[0]) begin
            lock_nxt  = wdata_r[`OSC_LOCK_BIT];
            sleep_on_wait_enable_nxt = wdata_r[`OSC_SLEEP_ON_WAIT_ENABLE_BIT];
          end
        end
      end else if (!key_wr) begin
        bresp_nxt = `OSC_RESP_DECERR;
      end
    end
    if (bvalid && bready) begin
      bvalid_nxt  = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end

    if (arvalid && arready) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = `OSC_RESP_OKAY;
      if (araddr == ADDR_W'(`OSC_CTRL_OFS)) begin
        rdata_nxt = ctrl_word;
      end else if (araddr == ADDR_W'(`OSC_KEY_OFS)) begin
        rdata_nxt = 32'h0000_0000;
      end else begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = `OSC_RESP_DECERR;
      end
    end
    if (rvalid && rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end

    // PLL stays on while requested or running the system clock
    pll_en_nxt = osc_pkg::is_pll_src(req_nxt) ||
                 osc_pkg::is_pll_src(sel_if.cur_src);
    system_pll_locked_nxt  = sys_pll_enable && (pin_s2_r[9] || tmr_done[0]);
    usb_pll_locked_nxt  = usb_pll_enable && (pin_s2_r[8] || tmr_done[1]);
    factor_nxt = fact_decode(fact_nxt);
    sleep_nxt  = wait_instr && sleep_on_wait_enable_r;
    idle_nxt   = wait_instr && !sleep_on_wait_enable_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r              <= `OSC_DIV_RST;
      fact_r             <= `OSC_FACT_RST;
      req_r              <= initial_source_config;
      lock_r             <= `OSC_LOCK_RST;
      sleep_on_wait_enable_r            <= `OSC_SLEEP_ON_WAIT_ENABLE_RST;
      usb_pll_locked_r            <= 1'b0;
      system_pll_locked_r            <= 1'b0;
      sys_pll_enable     <= 1'b0;
      pll_factor         <= 5'h0F;
      fast_rc_div_code   <= `OSC_DIV_RST;
      fast_rc_div_active <= 1'b0;
      sleep_enter        <= 1'b0;
      idle_enter         <= 1'b0;
      aw_held_r          <= 1'b0;
      w_held_r           <= 1'b0;
      aw_addr_r          <= '0;
      wdata_r            <= 32'h0000_0000;
      wstrb_r            <= 4'h0;
      awready            <= 1'b1;
      wready             <= 1'b1;
      bvalid             <= 1'b0;
      bresp              <= `OSC_RESP_OKAY;
      arready            <= 1'b1;
      rvalid             <= 1'b0;
      rdata              <= 32'h0000_0000;
      rresp              <= `OSC_RESP_OKAY;
    end else begin
      div_r              <= div_nxt;
      fact_r             <= fact_nxt;
      req_r              <= req_nxt;
      lock_r             <= lock_nxt;
      sleep_on_wait_enable_r            <= sleep_on_wait_enable_nxt;
      usb_pll_locked_r            <= usb_pll_locked_nxt;
      system_pll_locked_r            <= system_pll_locked_nxt;
      sys_pll_enable     <= pll_en_nxt;
      pll_factor         <= factor_nxt;
      fast_rc_div_code   <= div_nxt;
      fast_rc_div_active <= (sel_if.clk_sel == osc_pkg::src_fast_rc_divn);
      sleep_enter        <= sleep_nxt;
      idle_enter         <= idle_nxt;
      aw_held_r          <= aw_held_nxt;
      w_held_r           <= w_held_nxt;
      aw_addr_r          <= aw_addr_nxt;
      wdata_r            <= wdata_nxt;
      wstrb_r            <= wstrb_nxt;
      awready            <= awready_nxt;
      wready             <= wready_nxt;
      bvalid             <= bvalid_nxt;
      bresp              <= bresp_nxt;
      arready            <= arready_nxt;
      rvalid             <= rvalid_nxt;
      rdata              <= rdata_nxt;
      rresp              <= rresp_nxt;
    end
  end

endmodule : oscillator_select_control
